// file: include/count_step_if.sv
// Carrier between the timer core and its count step generator.
// Assumes both ends share one clock; the core drives mode and run bits.
`timescale 1ns/1ps
interface count_step_if;
    logic [7:0] mode;
    logic [1:0] run;
    logic [1:0] step;
    logic high_step;

    modport source (input mode, input run, output step, output high_step);
    modport sink (output mode, output run, input step, input high_step);
endinterface

// file: include/dual_timer_consts.svh
// Register indices, field positions and bus codes of the dual timer block.
// Assumes it is included by bare name and used alongside dual_timer_pkg.
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// Register indices; the byte address of each is four times its index.
`define IDX_STATUS 8'h80
`define IDX_MASK 8'h81
`define IDX_CONTROL 8'h88
`define IDX_MODE 8'h89
`define IDX_LOW0 8'h8A
`define IDX_LOW1 8'h8B
`define IDX_HIGH0 8'h8C
`define IDX_HIGH1 8'h8D

// Field positions inside one nibble of the mode register.
`define NIB_GATE 3
`define NIB_SOURCE 2

// Field positions inside the control register.
`define CTL_FLAG1 7
`define CTL_RUN1 6
`define CTL_FLAG0 5
`define CTL_RUN0 4

// Operating modes held in the two low bits of each nibble.
`define MODE_PRESCALE 2'h0
`define MODE_WIDE 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: include/dual_timer_pkg.sv
// Types of the dual timer block: the state records of both modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dual_timer_pkg;

    // Whole state of the top module: bus slave, registers and interrupt.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [11:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic [7:0] mode;
        logic [7:0] low0;
        logic [7:0] high0;
        logic [7:0] low1;
        logic [7:0] high1;
        logic [1:0] run;
        logic [1:0] flag;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
    } top_state_t;

    // State of the count step generator.
    typedef struct packed {
        logic [1:0] prev;
        logic [1:0] step;
        logic high_step;
    } step_state_t;

endpackage

// file: rtl/count_step.sv
// Count step generator: turns gating, source select and run bits into pulses.
// Assumes the pins are synchronous to aclk and the core reads steps one cycle later.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module count_step (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic external_irq_pin_zero,
    input wire logic external_irq_pin_one,
    input wire logic count_input_zero,
    input wire logic count_input_one,
    count_step_if.source bus
);
    import dual_timer_pkg::*;

    step_state_t s;
    step_state_t next_s;
    logic [1:0] gate_pin;
    logic [1:0] count_pin;
    logic [1:0] enable;
    logic [1:0] raw_step;

    assign gate_pin = {external_irq_pin_one, external_irq_pin_zero};
    assign count_pin = {count_input_one, count_input_zero};

    // Each unit reads its own nibble of the mode register.
    for (genvar u = 0; u < 2; u++) begin : g_unit
        logic gate;
        logic source;
        assign gate = bus.mode[4 * u + `NIB_GATE];
        assign source = bus.mode[4 * u + `NIB_SOURCE];
        // Run bit alone, or run bit and high pin when gated.
        assign enable[u] = bus.run[u] && (!gate || gate_pin[u]); // R1 R2 R14
        // Internal clock steps every cycle; counter mode needs a falling edge.
        assign raw_step[u] = enable[u] && (!source || (s.prev[u] && !count_pin[u])); // R3 R4
    end

    // The split high byte only looks at the second run bit.
    always_comb begin
        next_s = s;
        next_s.prev = count_pin;
        next_s.step = raw_step;
        next_s.high_step = bus.run[1]; // R11
    end

    // Steps are registered so the core sees clean one-cycle pulses.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.step = s.step;
    assign bus.high_step = s.high_step;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    gate_one_hold_a: assert property ((bus.mode[7] && !external_irq_pin_one) |=> !s.step[1]) // R1
        else $error("unit one stepped while gated off");
    gate_zero_hold_a: assert property ((bus.mode[3] && !external_irq_pin_zero) |=> !s.step[0]) // R2
        else $error("unit zero stepped while gated off");
    clock_source_a: assert property ((!bus.mode[6] && !bus.mode[7] && bus.run[1]) |=> s.step[1]) // R3
        else $error("unit one missed an internal clock step");
    falling_edge_a: assert property (($past(aresetn) && $fell(count_input_zero) && bus.mode[2] // R4
        && !bus.mode[3] && bus.run[0]) |=> s.step[0])
        else $error("unit zero missed a falling edge");
endmodule

// file: rtl/dual_timer.sv
// Dual timer/counter core with an AXI4-Lite register slave and one interrupt.
// Assumes one clock, synchronous inputs and an AXI4-Lite master on the bus.
//
// What this block does
// R1: Unit one gated by its interrupt pin.
// R2: Unit zero gated by its interrupt pin.
// R3: Unit one counts clock or falling edges.
// R4: Unit zero counts clock or falling edges.
// R5: Unit one configured by upper mode nibble.
// R6: Unit zero configured by lower mode nibble.
// R7: Mode 0: five-bit prescale into high byte.
// R8: Mode 1: plain sixteen-bit counter.
// R9: Mode 2: low byte reloads from high.
// R10: Mode 3: unit zero low byte own controls.
// R11: Mode 3: unit zero high byte uses unit one.
// R12: Unit one in mode 3 holds count.
// R13: Overflow flags set, cleared on service, writable.
// R14: Run bits switch counting on and off.
// R15: Count bytes readable and writable any time.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module dual_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_irq_pin_zero,
    input wire logic external_irq_pin_one,
    input wire logic count_input_zero,
    input wire logic count_input_one,
    input wire logic service_ack_zero,
    input wire logic service_ack_one,
    output logic irq
);
    import dual_timer_pkg::*;

    dual_timer_pkg::top_state_t s;
    dual_timer_pkg::top_state_t next_s;
    logic wr_do;
    logic [1:0] ev;
    logic [16:0] adv0;
    logic [16:0] adv1;
    logic [8:0] rd_hit;
    logic [8:0] wr_hit;
    logic split0;

    count_step_if cs();

    // Step generation is kept apart so edge detection stays in one place.
    count_step u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .external_irq_pin_zero(external_irq_pin_zero),
        .external_irq_pin_one(external_irq_pin_one),
        .count_input_zero(count_input_zero),
        .count_input_one(count_input_one),
        .bus(cs.source)
    );

    assign cs.mode = s.mode;
    assign cs.run = s.run;

    // True when a byte address equals the byte address of the given register index, which is four times the index.
    function automatic logic at(input logic [11:0] a, input logic [7:0] idx);
        at = (a == {2'b00, idx, 2'b00});
    endfunction

    // Read value of one register with a hit flag on top.
    function automatic logic [8:0] reg_value(input logic [11:0] a, input top_state_t t);
        logic [8:0] r;
        r = 9'h000;
        if (at(a, `IDX_STATUS)) begin
            r = {1'b1, 6'h00, t.ist};
        end else if (at(a, `IDX_MASK)) begin
            r = {1'b1, 6'h00, t.imask};
        end else if (at(a, `IDX_CONTROL)) begin
            r = {1'b1, t.flag[1], t.run[1], t.flag[0], t.run[0], 4'h0};
        end else if (at(a, `IDX_MODE)) begin
            r = {1'b1, t.mode};
        end else if (at(a, `IDX_LOW0)) begin
            r = {1'b1, t.low0};
        end else if (at(a, `IDX_LOW1)) begin
            r = {1'b1, t.low1};
        end else if (at(a, `IDX_HIGH0)) begin
            r = {1'b1, t.high0};
        end else if (at(a, `IDX_HIGH1)) begin
            r = {1'b1, t.high1};
        end
        reg_value = r;
    endfunction

    // One counting step of a unit in the given mode; result is {overflow, high, low}.
    // The three upper low-byte bits are left alone in prescale mode.
    function automatic logic [16:0] advance(input logic [1:0] m, input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (m)
            `MODE_PRESCALE: begin
                r[4:0] = lo[4:0] + 5'h01; // R7
                if (lo[4:0] == 5'h1F) begin
                    r[15:8] = hi + 8'h01;
                    r[16] = (hi == 8'hFF);
                end
            end
            `MODE_WIDE: begin
                r = {1'b0, hi, lo} + 17'h00001; // R8
            end
            `MODE_RELOAD: begin
                if (lo == 8'hFF) begin
                    r[7:0] = hi; // R9
                    r[16] = 1'b1;
                end else begin
                    r[7:0] = lo + 8'h01;
                end
            end
            default: begin
                r[7:0] = lo + 8'h01; // R10
                r[16] = (lo == 8'hFF);
            end
        endcase
        advance = r;
    endfunction

    assign adv0 = advance(s.mode[1:0], s.low0, s.high0); // R6
    assign adv1 = advance(s.mode[5:4], s.low1, s.high1); // R5
    assign split0 = (s.mode[1:0] == `MODE_SPLIT);
    assign rd_hit = reg_value(araddr, s);
    // The held write address is decoded apart, so the response code is a plain bit select.
    assign wr_hit = reg_value(s.waddr, s);

    // Next state: bus handshakes, counting, software writes, flags and interrupt.
    // Software writes are applied after counting so a write always replaces the count.
    always_comb begin
        next_s = s;
        wr_do = 1'b0;
        ev = 2'b00;

        // Write address and data are taken in either order and held until both arrive.
        if (s.awready && awvalid) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = awaddr;
        end
        if (s.wready && wvalid) begin
            next_s.w_got = 1'b1;
            next_s.wbyte = wdata[7:0];
            next_s.wlane = wstrb[0];
        end
        if (s.aw_got && s.w_got) begin
            wr_do = 1'b1;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit[8] ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken.
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s.arready && arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = {24'h000000, rd_hit[7:0]};
            next_s.rresp = rd_hit[8] ? `RESP_OKAY : `RESP_SLVERR;
            if (at(araddr, `IDX_STATUS)) begin
                next_s.ist = 2'b00;
            end
        end

        // Unit zero follows its own mode in every case.
        if (cs.step[0]) begin
            next_s.low0 = adv0[7:0];
            next_s.high0 = adv0[15:8];
            ev[0] = adv0[16]; // R10
        end
        // In split mode the high byte is a free timer owned by unit one's run bit.
        if (split0) begin
            next_s.high0 = s.high0;
            if (cs.high_step) begin
                next_s.high0 = s.high0 + 8'h01; // R11
                ev[1] = (s.high0 == 8'hFF);
            end
        end
        // Unit one stops in mode 3; its overflow flag belongs to the split high byte.
        if (cs.step[1] && (s.mode[5:4] != `MODE_SPLIT)) begin // R12
            next_s.low1 = adv1[7:0];
            next_s.high1 = adv1[15:8];
            ev[1] = ev[1] | (adv1[16] && !split0);
        end

        // Software writes; only the lowest byte lane carries register data.
        next_s.flag = s.flag & ~{service_ack_one, service_ack_zero}; // R13
        if (wr_do && s.wlane) begin
            if (at(s.waddr, `IDX_MODE)) begin
                next_s.mode = s.wbyte;
            end
            if (at(s.waddr, `IDX_LOW0)) begin
                next_s.low0 = s.wbyte; // R15
            end
            if (at(s.waddr, `IDX_HIGH0)) begin
                next_s.high0 = s.wbyte; // R15
            end
            if (at(s.waddr, `IDX_LOW1)) begin
                next_s.low1 = s.wbyte; // R15
            end
            if (at(s.waddr, `IDX_HIGH1)) begin
                next_s.high1 = s.wbyte; // R15
            end
            if (at(s.waddr, `IDX_MASK)) begin
                next_s.imask = s.wbyte[1:0];
            end
            if (at(s.waddr, `IDX_CONTROL)) begin
                next_s.run = {s.wbyte[`CTL_RUN1], s.wbyte[`CTL_RUN0]}; // R14
                next_s.flag = {s.wbyte[`CTL_FLAG1], s.wbyte[`CTL_FLAG0]}; // R13
            end
        end

        // Hardware setting beats any clear in the same cycle.
        next_s.flag = next_s.flag | ev; // R13
        next_s.ist = next_s.ist | ev;
        next_s.irq = |(next_s.ist & next_s.imask);

        // Ready signals follow the next state so every output stays a flop.
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // All state moves together on the clock; reset clears everything.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign irq = s.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    prescale_carry_a: assert property ((cs.step[0] && !wr_do && s.mode[1:0] == 2'h0 // R7
        && s.low0[4:0] == 5'h1F) |=> (s.high0 == $past(s.high0) + 8'h01 && s.low0[4:0] == 5'h00))
        else $error("prescaler did not carry into the high byte");
    wide_count_a: assert property ((cs.step[0] && !wr_do && s.mode[1:0] == 2'h1) // R8
        |=> ({s.high0, s.low0} == {$past(s.high0), $past(s.low0)} + 16'h0001))
        else $error("sixteen-bit count did not advance by one");
    reload_value_a: assert property ((cs.step[0] && !wr_do && s.mode[1:0] == 2'h2 // R9
        && s.low0 == 8'hFF) |=> (s.low0 == $past(s.high0) && s.flag[0]))
        else $error("low byte did not reload from the high byte");
    split_high_a: assert property ((split0 && cs.high_step && !wr_do) // R11
        |=> (s.high0 == $past(s.high0) + 8'h01))
        else $error("split high byte did not count");
    unit_one_hold_a: assert property ((s.mode[5:4] == 2'h3 && !wr_do) // R12
        |=> ($stable(s.low1) && $stable(s.high1)))
        else $error("unit one moved while stopped");
    flag_set_wins_a: assert property ((ev[0] && service_ack_zero) |=> s.flag[0]) // R13
        else $error("overflow lost against a clear");
    byte_write_a: assert property ((wr_do && s.wlane && at(s.waddr, 8'h8A)) // R15
        |=> (s.low0 == $past(s.wbyte)))
        else $error("count byte write did not land");
    run_off_still_a: assert property ((!s.run[0] && !wr_do && !split0) [*2] // R14
        |=> ($stable(s.low0) && $stable(s.high0)))
        else $error("unit zero counted with its run bit off");
    irq_level_a: assert property ((s.ist != 2'b00 && (s.ist & s.imask) == s.ist) |-> irq) // R13
        else $error("interrupt low while an unmasked event is pending");
endmodule

// file: sim/dual_timer_tb.sv
// Self-checking bench of the dual timer: AXI4-Lite master and scenario tasks.
// Assumes the pin model drives the count and gate pins of the design.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"
module dual_timer_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, service_ack_zero, service_ack_one;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic count_input_zero, count_input_one, external_irq_pin_zero, external_irq_pin_one;
    logic [31:0] v1, v2;
    logic [1:0] rs;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    localparam logic [11:0] a_status = {2'h0, `IDX_STATUS, 2'h0};
    localparam logic [11:0] a_mask = {2'h0, `IDX_MASK, 2'h0};
    localparam logic [11:0] a_ctl = {2'h0, `IDX_CONTROL, 2'h0};
    localparam logic [11:0] a_mode = {2'h0, `IDX_MODE, 2'h0};
    localparam logic [11:0] a_low0 = {2'h0, `IDX_LOW0, 2'h0};
    localparam logic [11:0] a_low1 = {2'h0, `IDX_LOW1, 2'h0};
    localparam logic [11:0] a_high0 = {2'h0, `IDX_HIGH0, 2'h0};
    localparam logic [11:0] a_high1 = {2'h0, `IDX_HIGH1, 2'h0};

    dual_timer dut (.*);
    pin_model pins (.aclk, .count_input_zero, .count_input_one,
        .external_irq_pin_zero, .external_irq_pin_one);

    // Free-running 100 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // A hung handshake must not stall the run, so a cycle ceiling ends it.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
                check({30'h0, bresp}, {30'h0, er});
            end
        end
        // A write that never answers counts against the run.
        if (!done) n_fail++;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        // A read that never answers counts against the run.
        if (!done) n_fail++;
    endtask

    task automatic expect_reg(input logic [11:0] a, input logic [7:0] e);
        rd(a, v1, rs);
        check(v1, {24'h000000, e});
        check({30'h0, rs}, {30'h0, `RESP_OKAY});
    endtask

    // Stop both units, then load mode, low and high bytes of one unit.
    task automatic setup(input logic [7:0] m, input int u, input logic [7:0] lo, hi);
        wr(a_ctl, 8'h00, `RESP_OKAY);
        wr(a_mode, m, `RESP_OKAY);
        wr(u == 0 ? a_low0 : a_low1, lo, `RESP_OKAY);
        wr(u == 0 ? a_high0 : a_high1, hi, `RESP_OKAY);
    endtask

    task automatic t_reset_and_bytes();
        expect_reg(a_mode, 8'h00);
        expect_reg(a_ctl, 8'h00);
        expect_reg(a_status, 8'h00);
        expect_reg(a_high1, 8'h00);
        // Count bytes are plain storage while stopped.
        wr(a_low1, 8'hA5, `RESP_OKAY);
        wr(a_high0, 8'h5A, `RESP_OKAY);
        expect_reg(a_low1, 8'hA5);
        expect_reg(a_high0, 8'h5A);
        wr(12'h3FC, 8'h11, `RESP_SLVERR);
        rd(12'h3FC, v1, rs);
        check({30'h0, rs}, {30'h0, `RESP_SLVERR});
        check(v1, 32'h0);
    endtask

    task automatic t_wide();
        setup(8'h05, 0, 8'hFE, 8'h12);
        wr(a_ctl, 8'h10, `RESP_OKAY);
        pins.pulse(0, 3);
        expect_reg(a_low0, 8'h01);
        expect_reg(a_high0, 8'h13);
    endtask

    task automatic t_prescale();
        setup(8'h04, 0, 8'hFF, 8'h05);
        wr(a_ctl, 8'h10, `RESP_OKAY);
        pins.pulse(0, 1);
        expect_reg(a_low0, 8'hE0);
        expect_reg(a_high0, 8'h06);
    endtask

    task automatic t_reload_irq();
        setup(8'h06, 0, 8'hFF, 8'hA0);
        wr(a_mask, 8'h01, `RESP_OKAY);
        wr(a_ctl, 8'h10, `RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        pins.pulse(0, 1);
        expect_reg(a_low0, 8'hA0);
        expect_reg(a_ctl, 8'h30);
        check({31'h0, irq}, 32'h1);
        expect_reg(a_status, 8'h01);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        expect_reg(a_status, 8'h00);
        // Service entry clears the flag but leaves the run bit alone.
        @(posedge aclk);
        service_ack_zero <= 1'b1;
        @(posedge aclk);
        service_ack_zero <= 1'b0;
        expect_reg(a_ctl, 8'h10);
        wr(a_ctl, 8'h20, `RESP_OKAY);
        expect_reg(a_ctl, 8'h20);
    endtask

    // Gated, pin-sourced, sixteen-bit mode on each unit in turn.
    task automatic t_gate();
        for (int u = 0; u < 2; u++) begin
            setup(u == 0 ? 8'h0D : 8'hD0, u, 8'h00, 8'h00);
            wr(a_ctl, u == 0 ? 8'h10 : 8'h40, `RESP_OKAY);
            pins.gate(u, 1'b0);
            pins.pulse(u, 2);
            expect_reg(u == 0 ? a_low0 : a_low1, 8'h00);
            pins.gate(u, 1'b1);
            pins.pulse(u, 2);
            expect_reg(u == 0 ? a_low0 : a_low1, 8'h02);
        end
    endtask

    task automatic t_internal();
        setup(8'h11, 0, 8'h00, 8'h00);
        wr(a_low1, 8'h00, `RESP_OKAY);
        wr(a_ctl, 8'h50, `RESP_OKAY);
        repeat (10) @(posedge aclk);
        rd(a_low0, v1, rs);
        check({31'h0, v1 !== 32'h0}, 32'h1);
        rd(a_low1, v1, rs);
        check({31'h0, v1 !== 32'h0}, 32'h1);
        wr(a_ctl, 8'h00, `RESP_OKAY);
        rd(a_low0, v1, rs);
        repeat (5) @(posedge aclk);
        rd(a_low0, v2, rs);
        check(v2, v1);
    endtask

    task automatic t_split();
        setup(8'h37, 0, 8'h00, 8'h00);
        wr(a_low1, 8'h55, `RESP_OKAY);
        wr(a_ctl, 8'h50, `RESP_OKAY);
        pins.pulse(0, 2);
        expect_reg(a_low0, 8'h02);
        expect_reg(a_low1, 8'h55);
        rd(a_high0, v1, rs);
        check({31'h0, v1 !== 32'h0}, 32'h1);
        // Clearing the unit one run bit must freeze the split high byte.
        wr(a_ctl, 8'h10, `RESP_OKAY);
        rd(a_high0, v1, rs);
        repeat (5) @(posedge aclk);
        rd(a_high0, v2, rs);
        check(v2, v1);
    endtask

    // Unit one reloads from a pin edge, raises its own status bit and is serviced.
    task automatic t_reload_one();
        setup(8'h60, 1, 8'hFF, 8'h33);
        wr(a_mask, 8'h02, `RESP_OKAY);
        wr(a_ctl, 8'h40, `RESP_OKAY);
        pins.pulse(1, 1);
        expect_reg(a_low1, 8'h33);
        check({31'h0, irq}, 32'h1);
        expect_reg(a_ctl, 8'hC0);
        expect_reg(a_status, 8'h02);
        expect_reg(a_status, 8'h00);
        @(posedge aclk);
        service_ack_one <= 1'b1;
        @(posedge aclk);
        service_ack_one <= 1'b0;
        expect_reg(a_ctl, 8'h40);
    endtask

    // All inputs get a value at time zero; reset is held for four cycles.
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {service_ack_zero, service_ack_one} = 2'h0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_and_bytes();
        t_wide();
        t_prescale();
        t_reload_irq();
        t_gate();
        t_internal();
        t_split();
        t_reload_one();
        final_report();
    end
endmodule

// file: sim/pin_model.sv
// Model of the pins outside the timer: two count inputs and two gate pins.
// Assumes one shared clock; every pin changes just after a rising edge.
`timescale 1ns/1ps
module pin_model (
    input wire logic aclk,
    output logic count_input_zero,
    output logic count_input_one,
    output logic external_irq_pin_zero,
    output logic external_irq_pin_one
);
    // Count pins idle high so that no stray falling edge is seen after reset.
    initial begin
        count_input_zero = 1'b1;
        count_input_one = 1'b1;
        external_irq_pin_zero = 1'b1;
        external_irq_pin_one = 1'b1;
    end

    // Each pulse is two cycles low and three high, slow enough for the edge detector.
    task automatic pulse(input int unit, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (unit == 0) count_input_zero <= 1'b0;
            else count_input_one <= 1'b0;
            repeat (2) @(posedge aclk);
            if (unit == 0) count_input_zero <= 1'b1;
            else count_input_one <= 1'b1;
            repeat (2) @(posedge aclk);
        end
        // The count lands two edges after the pin falls, so let it settle.
        repeat (4) @(posedge aclk);
    endtask

    // Gate level is held until changed again.
    task automatic gate(input int unit, input logic level);
        @(posedge aclk);
        if (unit == 0) external_irq_pin_zero <= level;
        else external_irq_pin_one <= level;
        @(posedge aclk);
    endtask
endmodule
